// ### pfh_pkg.sv
// How it works
// RL1 - Read: address out, chip select and output enable low, write strobe high.
// RL2 - Device floats data whenever chip select or output enable is high.
// RL3 - Device latches address on strobe fall, data on strobe rise.
// RL4 - Write: chip select low, output enable high, data out, pulse strobe low.
// RL5 - Host never issues an undefined command to the device.
// RL6 - Reset low for minimum time returns device to read mode, data floats.
// RL7 - Reset during program or erase reaches read mode within recovery time.
// RL8 - Device holds ready_busy_n low until back in read mode after reset.
// RL9 - Reset and chip select high means standby; strobes ignored, data floats.
// RL10 - Active mode: output enable high floats data, low drives data.
// RL11 - Width select high gives word mode on all sixteen data lines.
// RL12 - Width select low: low byte only, top data line becomes lowest address.
// RL13 - Accelerate high voltage during write unprotects every sector.
// RL14 - Protect pin low keeps the two outermost boot sectors protected.
// RL15 - Protect pin high restores earlier boot sector protection state.
// RL16 - Device turns data lines between input and output as sequence needs.
// RL17 - System reset should also drive the flash reset pin.
// RL18 - Lock read: high voltage address line, A6 A0 low, A1 high; bit0 shows lock.
// RL19 - High voltage address line with A6 A1 A0 low returns maker code.
// RL20 - High voltage, A6 low, A1 A0 high returns 99h locked, 19h otherwise.
// RL21 - High voltage reset lets protected sectors be programmed and erased.
// RL22 - Each pin's high voltage level is a separate qualifier signal.
package pfh_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	// Times in ns; clock period 100 ns
	localparam int CLK_NS = 100;
	localparam int SETUP_NS = 100;
	localparam int ACCESS_NS = 90;
	localparam int STROBE_NS = 50;
	localparam int RESET_PULSE_MIN_NS = 500;
	localparam int RESET_RECOVERY_NS = 20000;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESET_RECOVERY_CYC = (RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W = 16;
	// Autoselect address pattern bits
	localparam int AS_BIT_A0 = 0;
	localparam int AS_BIT_A1 = 1;
	localparam int AS_BIT_A6 = 6;
	localparam logic [7:0] LOCKED_CODE = 8'h99;
	localparam logic [7:0] UNLOCKED_CODE = 8'h19;

	typedef enum logic [2:0] {
		PFH_IDLE = 3'b000,
		PFH_RD_SETUP = 3'b001,
		PFH_RD_WAIT = 3'b010,
		PFH_WR_SETUP = 3'b011,
		PFH_WR_STROBE = 3'b100,
		PFH_WR_HOLD = 3'b101,
		PFH_RST_PULSE = 3'b110,
		PFH_RST_WAIT = 3'b111
	} pfh_state_t;

	typedef enum logic [1:0] {
		PFH_OP_READ = 2'h0,
		PFH_OP_WRITE = 2'h1,
		PFH_OP_RESET = 2'h2,
		PFH_OP_AUTOSEL = 2'h3
	} pfh_op_t;

	typedef struct packed {
		pfh_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pfh_req_t;

	// Pins to the flash
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_strobe_n;
		logic hw_reset_n;
		logic hw_reset_hv;
		logic width_select_n;
		logic protect_accel_in;
		logic protect_accel_hv;
		logic autoselect_hv;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic data_oe;
	} pfh_pins_t;

	typedef struct packed {
		pfh_state_t state;
		logic [CNT_W-1:0] cnt;
		pfh_pins_t pins;
		logic [DATA_W-1:0] rdata;
		logic rvalid;
		logic [1:0] rdy_sync;
		logic [1:0] rst_hist;
	} pfh_regs_t;
endpackage

// ### pfh_host.sv
`timescale 1ns/1ps
`default_nettype none
module pfh_host
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Request side
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire pfh_pkg::pfh_req_t req_i,
	output logic [pfh_pkg::DATA_W-1:0] rdata_o,
	output logic rvalid_o,
	output logic busy_o,
	// Static modes
	input wire logic word_mode_i,
	input wire logic write_protect_i,
	input wire logic accel_i,
	input wire logic temp_unprotect_i,
	// Flash pins
	output pfh_pkg::pfh_pins_t pins_o,
	input wire logic [pfh_pkg::DATA_W-1:0] data_in_i,
	input wire logic ready_busy_n_i
);
	import pfh_pkg::*;

	pfh_regs_t r;
	pfh_regs_t next_r;
	logic [DATA_W-1:0] data_sync1;
	logic [DATA_W-1:0] data_sync2;
	logic flash_ready;

	assign flash_ready = r.rdy_sync[1];
	assign req_ready_o = (r.state == PFH_IDLE) && flash_ready && !rst_i;
	assign rdata_o = r.rdata;
	assign rvalid_o = r.rvalid;
	assign busy_o = (r.state != PFH_IDLE) || !flash_ready;
	assign pins_o = r.pins;

	always_comb
	begin
		next_r = r;
		next_r.rvalid = 1'b0;
		next_r.rdy_sync = {r.rdy_sync[0], ready_busy_n_i};
		next_r.rst_hist = {r.rst_hist[0], 1'b1};
		// Width only changes between transfers, never inside one
		if (r.state == PFH_IDLE)
			next_r.pins.width_select_n = word_mode_i; // RL11 RL12
		// Low level protects boot sectors; high restores prior state; hv unprotects all
		next_r.pins.protect_accel_in = !write_protect_i; // RL14 RL15
		next_r.pins.protect_accel_hv = accel_i; // RL13 RL22
		case (r.state)
			PFH_IDLE:
			begin
				next_r.pins.chip_select_n = 1'b1; // RL9
				next_r.pins.output_enable_n = 1'b1;
				next_r.pins.write_strobe_n = 1'b1;
				next_r.pins.data_oe = 1'b0;
				next_r.pins.autoselect_hv = 1'b0;
				next_r.cnt = '0;
				if (r.rst_hist[1] == 1'b0)
				begin
					// System reset also resets the flash
					next_r.state = PFH_RST_PULSE; // RL17
					next_r.pins.hw_reset_n = 1'b0;
				end
				else if (req_valid_i && flash_ready)
				begin
					next_r.pins.addr = req_i.addr;
					// Byte reads: the lowest address bit rides on the top data line, which
					// stays undriven while reading, so only a pull on that line picks the byte
					if (!word_mode_i)
						next_r.pins.data_out = {req_i.addr[0], 15'h0000}; // RL12
					case (req_i.op)
						PFH_OP_READ:
						begin
							next_r.state = PFH_RD_SETUP;
							next_r.pins.chip_select_n = 1'b0;
						end
						PFH_OP_AUTOSEL:
						begin
							// Caller sets A6/A1/A0 for lock, maker or indicator reads
							next_r.state = PFH_RD_SETUP;
							next_r.pins.chip_select_n = 1'b0;
							next_r.pins.autoselect_hv = 1'b1; // RL18 RL19 RL20
						end
						PFH_OP_WRITE:
						begin
							// Caller supplies only defined command cycles
							next_r.state = PFH_WR_SETUP; // RL5
							next_r.pins.chip_select_n = 1'b0;
							if (word_mode_i)
								next_r.pins.data_out = req_i.wdata; // RL11
							else
								next_r.pins.data_out = {req_i.addr[0], 7'h00, req_i.wdata[7:0]}; // RL12
							next_r.pins.data_oe = 1'b1; // RL4 RL16
						end
						PFH_OP_RESET:
						begin
							next_r.state = PFH_RST_PULSE;
							next_r.pins.hw_reset_n = 1'b0; // RL6
						end
						default:
							next_r.state = PFH_IDLE;
					endcase
				end
			end
			PFH_RD_SETUP:
			begin
				next_r.pins.output_enable_n = 1'b0; // RL1 RL10
				next_r.state = PFH_RD_WAIT;
				next_r.cnt = '0;
			end
			PFH_RD_WAIT:
			begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt >= CNT_W'(ACCESS_CYC + 2))
				begin
					// Sample after the two-stage data synchroniser settles
					if (r.pins.width_select_n)
						next_r.rdata = data_sync2; // RL11
					else
						next_r.rdata = {8'h00, data_sync2[7:0]}; // RL12
					next_r.rvalid = 1'b1;
					next_r.pins.output_enable_n = 1'b1; // RL2
					next_r.pins.chip_select_n = 1'b1;
					next_r.pins.autoselect_hv = 1'b0;
					next_r.state = PFH_IDLE;
				end
			end
			PFH_WR_SETUP:
			begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt >= CNT_W'(SETUP_CYC - 1))
				begin
					// Address latched by the device on this fall
					next_r.pins.write_strobe_n = 1'b0; // RL3 RL4
					next_r.cnt = '0;
					next_r.state = PFH_WR_STROBE;
				end
			end
			PFH_WR_STROBE:
			begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt >= CNT_W'(STROBE_CYC - 1))
				begin
					// Data latched on this rise; keep data driven one more cycle
					next_r.pins.write_strobe_n = 1'b1; // RL3
					next_r.state = PFH_WR_HOLD;
				end
			end
			PFH_WR_HOLD:
			begin
				// Data stayed driven through the strobe rise; release the bus now
				next_r.pins.chip_select_n = 1'b1;
				next_r.pins.data_oe = 1'b0; // RL16
				next_r.state = PFH_IDLE;
			end
			PFH_RST_PULSE:
			begin
				next_r.cnt = r.cnt + 1'b1;
				if (r.cnt >= CNT_W'(RESET_PULSE_CYC - 1))
				begin
					next_r.pins.hw_reset_n = 1'b1; // RL6
					next_r.cnt = '0;
					next_r.state = PFH_RST_WAIT;
				end
			end
			PFH_RST_WAIT:
			begin
				// Wait for ready or the recovery bound, whichever first
				next_r.cnt = r.cnt + 1'b1;
				if ((flash_ready && r.cnt >= CNT_W'(2))
					|| r.cnt >= CNT_W'(RESET_RECOVERY_CYC)) // RL7 RL8
					next_r.state = PFH_IDLE;
			end
			default:
				next_r.state = PFH_IDLE;
		endcase

		// The reset pin's high level never overlaps a low reset pulse
		if (next_r.pins.hw_reset_n)
			next_r.pins.hw_reset_hv = temp_unprotect_i; // RL21 RL22
		else
			next_r.pins.hw_reset_hv = 1'b0; // RL6
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			r <= '0;
			r.state <= PFH_IDLE;
			r.pins.chip_select_n <= 1'b1;
			r.pins.output_enable_n <= 1'b1;
			r.pins.write_strobe_n <= 1'b1;
			r.pins.hw_reset_n <= 1'b0; // RL17
			r.pins.width_select_n <= 1'b1;
			r.pins.protect_accel_in <= 1'b1;
		end
		else
			r <= next_r;
	end

	// Two-stage synchroniser for the data bus
	// Only the second stage feeds logic; the first may still be settling
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_sync1 <= '0;
			data_sync2 <= '0;
		end
		else
		begin
			data_sync1 <= data_in_i;
			data_sync2 <= data_sync1;
		end
	end
endmodule
`default_nettype wire

// ### pfh_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pfh_host_sva
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Request side
	input wire logic req_valid_i,
	input wire logic req_ready_o,
	input wire pfh_pkg::pfh_req_t req_i,
	input wire logic rvalid_o,
	// Flash pins
	input wire pfh_pkg::pfh_pins_t pins_o
);
	import pfh_pkg::*;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);
	read_ctrl_a: assert property (!pins_o.output_enable_n |->
		!pins_o.chip_select_n && pins_o.write_strobe_n && !pins_o.data_oe)
		else $error("read enable without select");
	write_ctrl_a: assert property (!pins_o.write_strobe_n |->
		!pins_o.chip_select_n && pins_o.output_enable_n && pins_o.data_oe)
		else $error("write strobe without select or data");
	write_hold_a: assert property (!pins_o.write_strobe_n |=>
		pins_o.write_strobe_n && $stable(pins_o.addr) && $stable(pins_o.data_out))
		else $error("write address or data moved");
	reset_pulse_a: assert property ($fell(pins_o.hw_reset_n) |->
		!pins_o.hw_reset_n [*5])
		else $error("flash reset pulse too short");
	reset_float_a: assert property (!pins_o.hw_reset_n |->
		!pins_o.data_oe && pins_o.chip_select_n)
		else $error("bus active during flash reset");
	sys_reset_a: assert property ($fell(rst_i) |-> !pins_o.hw_reset_n)
		else $error("flash reset not tied to system reset");
	read_walk_a: assert property (req_valid_i && req_ready_o && req_i.op == PFH_OP_READ
		|=> !pins_o.chip_select_n && pins_o.output_enable_n ##1 !pins_o.output_enable_n
		##[3:6] rvalid_o)
		else $error("read sequence wrong");
	autosel_hv_a: assert property (req_valid_i && req_ready_o && req_i.op == PFH_OP_AUTOSEL
		|=> pins_o.autoselect_hv && !pins_o.chip_select_n)
		else $error("autoselect level missing");
	hv_reset_a: assert property (pins_o.hw_reset_hv |-> pins_o.hw_reset_n)
		else $error("high voltage during reset");
	idle_strobes_a: assert property (pins_o.chip_select_n |->
		pins_o.output_enable_n && pins_o.write_strobe_n)
		else $error("strobe active while deselected");
endmodule
bind pfh_host pfh_host_sva i_pfh_host_sva (.sys_clk_i, .rst_i, .req_valid_i, .req_ready_o,
	.req_i, .rvalid_o, .pins_o);
`default_nettype wire

// ### pfh_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfh_flash_model
#(
	parameter int BUSY_NS = 800,
	parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
	parameter bit FACTORY_LOCKED = 1'b1
)
(
	// Pins from the host
	input wire pfh_pkg::pfh_pins_t pins_i,
	// Resolved data wire and status
	output logic [pfh_pkg::DATA_W-1:0] data_o,
	output logic ready_busy_n_o
);
	import pfh_pkg::*;
	logic [15:0] mem [256];
	logic [20:0] wr_addr;
	logic [15:0] dout;
	logic flip = 1'b0;
	logic drive;
	logic locked;
	initial
	begin
		foreach (mem[i])
			mem[i] = 16'hFFFF;
		ready_busy_n_o = 1'b1;
	end
	// Undriven lines show a pattern that changes every half cycle
	always #50 flip = ~flip;
	always @(negedge pins_i.write_strobe_n)
		wr_addr = pins_i.addr;
	always @(posedge pins_i.write_strobe_n)
		if (!pins_i.chip_select_n && pins_i.output_enable_n && pins_i.hw_reset_n
			&& !(wr_addr[20:13] == 8'h00 && locked))
			mem[wr_addr[7:0]] = pins_i.width_select_n ? pins_i.data_out
				: {mem[wr_addr[7:0]][15:8], pins_i.data_out[7:0]};
	always @(negedge pins_i.hw_reset_n)
		ready_busy_n_o = 1'b0;
	always @(posedge pins_i.hw_reset_n)
	begin
		#(BUSY_NS);
		ready_busy_n_o = pins_i.hw_reset_n;
	end
	always_comb
	begin
		locked = !pins_i.protect_accel_in && !pins_i.protect_accel_hv && !pins_i.hw_reset_hv;
		drive = pins_i.hw_reset_n && !pins_i.chip_select_n && !pins_i.output_enable_n;
		dout = mem[pins_i.addr[7:0]];
		if (pins_i.autoselect_hv && !pins_i.addr[6])
			case (pins_i.addr[1:0])
				2'h0: dout = {8'h00, MAKER_ID};
				2'h2: dout = {15'h0000, pins_i.addr[20:13] == 8'h00 && !pins_i.protect_accel_in};
				2'h3: dout = FACTORY_LOCKED ? 16'h0099 : 16'h0019;
				default: dout = 16'h0000;
			endcase
		for (int b = 0; b < 16; b++)
			if (pins_i.data_oe)
				data_o[b] = pins_i.data_out[b];
			else if (drive && (pins_i.width_select_n || b < 8))
				data_o[b] = dout[b];
			else
				data_o[b] = flip ^ b[0];
	end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pfh_pkg::*;
	typedef struct packed {
		logic [1:0] op;
		logic [20:0] a;
		logic [15:0] d;
		logic [3:0] m;
		logic [15:0] e;
	} pfh_row_t;
	// Mode column: word, protect, accelerate, temporary unprotect
	localparam pfh_row_t ROWS [17] = '{
		'{2'h1, 21'h003000, 16'h1234, 4'h8, 16'h0000},
		'{2'h0, 21'h003000, 16'h0000, 4'h8, 16'h1234},
		'{2'h1, 21'h003001, 16'hABCD, 4'h8, 16'h0000},
		'{2'h0, 21'h003001, 16'h0000, 4'h0, 16'h00CD},
		'{2'h1, 21'h003001, 16'h00EE, 4'h0, 16'h0000},
		'{2'h0, 21'h003001, 16'h0000, 4'h8, 16'hABEE},
		'{2'h3, 21'h000000, 16'h0000, 4'h8, 16'h005A},
		'{2'h3, 21'h000002, 16'h0000, 4'hC, 16'h0001},
		'{2'h3, 21'h000002, 16'h0000, 4'h8, 16'h0000},
		'{2'h3, 21'h000003, 16'h0000, 4'h8, 16'h0099},
		'{2'h1, 21'h000020, 16'h5555, 4'hC, 16'h0000},
		'{2'h0, 21'h000020, 16'h0000, 4'hC, 16'hFFFF},
		'{2'h1, 21'h000020, 16'h6666, 4'hE, 16'h0000},
		'{2'h1, 21'h000021, 16'h7777, 4'hD, 16'h0000},
		'{2'h2, 21'h000000, 16'h0000, 4'h9, 16'h0000},
		'{2'h0, 21'h000020, 16'h0000, 4'hC, 16'h6666},
		'{2'h0, 21'h000021, 16'h0000, 4'hC, 16'h7777}};
	logic sys_clk_i, rst_i, req_valid_i, req_ready_o, rvalid_o, busy_o, ready_busy_n_i;
	logic word_mode_i, write_protect_i, accel_i, temp_unprotect_i;
	logic [DATA_W-1:0] rdata_o, data_in_i, q;
	pfh_req_t req_i;
	pfh_pins_t pins_o;
	int mismatches, tests_run, cycles;
	pfh_host i_pfh_host (.sys_clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_i, .rdata_o,
		.rvalid_o, .busy_o, .word_mode_i, .write_protect_i, .accel_i, .temp_unprotect_i,
		.pins_o, .data_in_i, .ready_busy_n_i);
	pfh_flash_model i_pfh_flash_model (.pins_i(pins_o), .data_o(data_in_i),
		.ready_busy_n_o(ready_busy_n_i));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Entered at a falling edge; read data lands in q
	task automatic do_req(input pfh_op_t op, input logic [20:0] a, input logic [15:0] d);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 400)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		req_i = '{op, a, d};
		req_valid_i = 1'b1;
		@(negedge sys_clk_i);
		req_valid_i = 1'b0;
		q = 'x;
		do
		begin
			@(negedge sys_clk_i);
			n++;
			if (rvalid_o === 1'b1)
				q = rdata_o;
		end
		while (busy_o !== 1'b0 && n < 800);
	endtask
	initial
	begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	initial
	begin
		{rst_i, req_valid_i, req_i, cycles, mismatches, tests_run} = '0;
		rst_i = 1'b1;
		{word_mode_i, write_protect_i, accel_i, temp_unprotect_i} = 4'h8;
		repeat (12) @(negedge sys_clk_i);
		rst_i = 1'b0;
		foreach (ROWS[i])
		begin
			{word_mode_i, write_protect_i, accel_i, temp_unprotect_i} = ROWS[i].m;
			do_req(pfh_op_t'(ROWS[i].op), ROWS[i].a, ROWS[i].d);
			if (ROWS[i].op == 2'h0 || ROWS[i].op == 2'h3)
				check("rdata", q, ROWS[i].e);
		end
		// System reset in the middle of a write strobe
		req_i = '{PFH_OP_WRITE, 21'h003000, 16'h4321};
		req_valid_i = 1'b1;
		@(negedge sys_clk_i);
		req_valid_i = 1'b0;
		@(negedge sys_clk_i);
		rst_i = 1'b1;
		@(negedge sys_clk_i);
		check("reset pins", {13'h0, pins_o.hw_reset_n, pins_o.chip_select_n, pins_o.data_oe},
			16'h0002);
		rst_i = 1'b0;
		@(negedge sys_clk_i);
		check("busy after reset", {15'h0, busy_o}, 16'h0001);
		do_req(PFH_OP_READ, 21'h003000, 16'h0000);
		check("rdata", q, 16'h1234);
		wrap_up();
	end
endmodule
`default_nettype wire
